// ==== include/eeprom_host_pkg.sv ====
// Purpose: shared constants and types for the two-wire EEPROM host
// Assumes: pclk at 40 MHz, APB register access
// Notes: offsets are byte addresses, one 32-bit word per register
package eeprom_host_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    // Quarter of the serial clock period; four quarters make one bit
    localparam int QUARTER_NS = 625;
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CFG = 12'h004;
    localparam logic [11:0] OFF_ADDR = 12'h008;
    localparam logic [11:0] OFF_COUNT = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [3:0] OFF_BUF_PAGE = 4'h1;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 4;
    localparam int STAT_DONE_BIT = 1;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [6:0] COUNT_RST = 7'h01;
    localparam logic [6:0] READ_MAX = 7'h40;
    // ------------------------------------------------------------
    // Device frame fields
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_ID = 4'hB;
    localparam logic [7:0] LOCK_ADDR_HI = 8'h04;
    localparam logic [7:0] LOCK_DATA = 8'h02;
    localparam logic [7:0] QUERY_DATA = 8'h00;
    typedef enum logic [1:0] {
        LC_START = 2'h0,
        LC_STOP = 2'h1,
        LC_WRITE = 2'h2,
        LC_READ = 2'h3
    } line_cmd_e;
    typedef enum logic [2:0] {
        OP_CUR = 3'h0,
        OP_RAND = 3'h1,
        OP_ID = 3'h2,
        OP_LOCK = 3'h3,
        OP_QUERY = 3'h4
    } op_e;
endpackage : eeprom_host_pkg

// ==== include/bit_if.sv ====
// Purpose: bit-level command path between sequencer and line engine
// Assumes: both ends on pclk
// Notes: go is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface bit_if;
    logic go;
    eeprom_host_pkg::line_cmd_e cmd;
    logic wbit;
    logic done;
    logic rbit;
    modport seq (output go, output cmd, output wbit, input done, input rbit);
    modport eng (input go, input cmd, input wbit, output done, output rbit);
endinterface : bit_if
`default_nettype wire

// ==== hdl/bit_engine.sv ====
// Purpose: drives serial clock and open-drain data for one line symbol
// Assumes: serial clock is made here by dividing pclk
// Notes: one symbol lasts four quarters of the serial clock period
`timescale 1ns/1ps
`default_nettype none
module bit_engine (
    input wire logic pclk,
    input wire logic presetn,
    bit_if.eng bus,
    input wire logic sda_i,
    output logic scl,
    output logic sda_o,
    output logic sda_oe
);
    localparam int QW = $clog2(eeprom_host_pkg::QUARTER_CYC);

    logic sda_s1_q;
    logic sda_s2_q;
    logic run_q;
    logic [1:0] ph_q;
    logic [QW-1:0] cnt_q;
    eeprom_host_pkg::line_cmd_e cmd_q;
    logic bit_q;

    // ------------------------------------------------------------
    // Line levels per quarter, returned as {scl, sda}
    // ------------------------------------------------------------
    function automatic logic [1:0] lines(eeprom_host_pkg::line_cmd_e c, logic [1:0] p,
                                         logic b);
        unique case (c)
            eeprom_host_pkg::LC_START: lines = {p[0] ^ p[1], ~p[1]};
            eeprom_host_pkg::LC_STOP: lines = {|p, p[1]};
            eeprom_host_pkg::LC_WRITE: lines = {p[0] ^ p[1], b};
            eeprom_host_pkg::LC_READ: lines = {p[0] ^ p[1], 1'b1};
        endcase
    endfunction : lines

    wire quarter_end = run_q && (cnt_q == QW'(eeprom_host_pkg::QUARTER_CYC - 1));
    wire last_ph = (ph_q == 2'h3);
    wire [1:0] ph_next = ph_q + 2'h1;
    wire [1:0] go_lines = lines(bus.cmd, 2'h0, bus.wbit);
    wire [1:0] step_lines = lines(cmd_q, ph_next, bit_q);
    wire start_go = bus.go && !run_q;

    // ------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Quarter sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            ph_q <= 2'h0;
            cnt_q <= '0;
            cmd_q <= eeprom_host_pkg::LC_STOP;
            bit_q <= 1'b1;
            scl <= 1'b1;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            bus.done <= 1'b0;
            bus.rbit <= 1'b1;
        end else begin
            bus.done <= quarter_end && last_ph;
            sda_o <= 1'b0;
            if (start_go) begin
                run_q <= 1'b1;
                ph_q <= 2'h0;
                cnt_q <= '0;
                cmd_q <= bus.cmd;
                bit_q <= bus.wbit;
                scl <= go_lines[1];
                sda_oe <= ~go_lines[0];
            end else if (quarter_end) begin
                cnt_q <= '0;
                ph_q <= ph_next;
                run_q <= !last_ph;
                if (!last_ph) begin
                    scl <= step_lines[1];
                    sda_oe <= ~step_lines[0];
                end
                // Sample late in the high time, well after data settles
                if (ph_q == 2'h2) begin
                    bus.rbit <= sda_s2_q;
                end
            end else if (run_q) begin
                cnt_q <= cnt_q + QW'(1);
            end
        end
    end
endmodule : bit_engine
`default_nettype wire

// ==== hdl/eeprom_host.sv ====
// Purpose: APB-controlled host that reads a two-wire EEPROM and its ID page
// Assumes: pclk at 40 MHz; the serial clock is derived here
// Notes: bytes read land in a 64-entry buffer visible on APB
//
// Notes on behaviour
// - Lock command is a byte write framed with device type 1011b.
// - Lock address carries the lock-select bit set; other bits ignored.
// - Lock data byte has bit 1 set; other bits don't care.
// - Reads open with start and slave address, direction bit one.
// - Single current read ends with master no-acknowledge then stop.
// - Random read: write address header, byte address, restart, read header.
// - Each master acknowledge brings the next byte from counter plus one.
// - Sequential read ends with no-acknowledge on last byte, then stop.
// - ID page read is random read with type 1011b; six low bits select.
// - ID page reads never run past the 64-byte page end.
// - After lock query master sends start, discarding the truncated write.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_START = 7'h02,
        S_TX = 7'h04,
        S_TXACK = 7'h08,
        S_RX = 7'h10,
        S_RXACK = 7'h20,
        S_STOP = 7'h40
    } state_e;

    state_e state_q;
    eeprom_host_pkg::op_e op_q;
    logic [2:0] hw_q;
    logic [15:0] addr_q;
    logic [6:0] count_q;
    logic done_q;
    logic nack_q;
    logic locked_q;
    logic [1:0] idx_q;
    logic [2:0] bitn_q;
    logic [7:0] sh_q;
    logic rd_phase_q;
    logic tail_q;
    logic [6:0] len_q;
    logic [6:0] got_q;
    logic wait_q;
    logic go_q;
    logic [7:0] buf_mem [0:63];

    bit_if lnk ();

    bit_engine u_eng (
        .pclk(pclk),
        .presetn(presetn),
        .bus(lnk.eng),
        .sda_i(sda_i),
        .scl(scl),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    // ------------------------------------------------------------
    // Byte to send for a given frame position
    // ------------------------------------------------------------
    function automatic logic [7:0] tx_byte(eeprom_host_pkg::op_e op, logic [1:0] idx,
                                           logic rd, logic [2:0] hw, logic [15:0] a);
        logic [3:0] typ;
        typ = (op == eeprom_host_pkg::OP_CUR || op == eeprom_host_pkg::OP_RAND) ?
              eeprom_host_pkg::TYPE_ARRAY : eeprom_host_pkg::TYPE_ID;
        if (rd || idx == 2'h0) begin
            tx_byte = {typ, hw, rd};
        end else if (idx == 2'h1) begin
            tx_byte = (op == eeprom_host_pkg::OP_LOCK) ? eeprom_host_pkg::LOCK_ADDR_HI :
                      (op == eeprom_host_pkg::OP_RAND) ? a[15:8] : 8'h00;
        end else if (idx == 2'h2) begin
            tx_byte = (op == eeprom_host_pkg::OP_RAND) ? a[7:0] :
                      (op == eeprom_host_pkg::OP_ID) ? {2'b00, a[5:0]} : 8'h00;
        end else begin
            tx_byte = (op == eeprom_host_pkg::OP_LOCK) ? eeprom_host_pkg::LOCK_DATA :
                      eeprom_host_pkg::QUERY_DATA;
        end
    endfunction : tx_byte

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire idle = (state_q == S_IDLE);
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pready && pwrite;
    wire hit_ctrl = (paddr == eeprom_host_pkg::OFF_CTRL);
    wire hit_cfg = (paddr == eeprom_host_pkg::OFF_CFG);
    wire hit_addr = (paddr == eeprom_host_pkg::OFF_ADDR);
    wire hit_count = (paddr == eeprom_host_pkg::OFF_COUNT);
    wire hit_stat = (paddr == eeprom_host_pkg::OFF_STATUS);
    wire hit_buf = (paddr[11:8] == eeprom_host_pkg::OFF_BUF_PAGE) && (paddr[1:0] == 2'b00);
    wire mapped = hit_ctrl || hit_cfg || hit_addr || hit_count || hit_stat || hit_buf;
    wire [2:0] op_field = pwdata[eeprom_host_pkg::CTRL_OP_LSB +: 3];
    wire op_ok = (op_field <= eeprom_host_pkg::OP_QUERY);
    wire launch = wr_acc && hit_ctrl && pwdata[eeprom_host_pkg::CTRL_GO_BIT] && idle && op_ok;
    wire done_clr = wr_acc && hit_stat && pwdata[eeprom_host_pkg::STAT_DONE_BIT];
    wire cfg_wr = wr_acc && idle;
    wire [31:0] rd_word =
        hit_ctrl ? {25'h0, op_q, 3'h0, !idle} :
        hit_cfg ? {29'h0, hw_q} :
        hit_addr ? {16'h0, addr_q} :
        hit_count ? {25'h0, count_q} :
        hit_stat ? {17'h0, got_q, 4'h0, locked_q, nack_q, done_q, !idle} :
        hit_buf ? {24'h0, buf_mem[paddr[7:2]]} : 32'h0000_0000;

    // ------------------------------------------------------------
    // Read length, clipped to the ID page end
    // ------------------------------------------------------------
    wire [6:0] cnt_lim = (count_q == 7'h00) ? 7'h01 :
                         (count_q > eeprom_host_pkg::READ_MAX) ? eeprom_host_pkg::READ_MAX :
                         count_q;
    wire [6:0] id_room = eeprom_host_pkg::READ_MAX - {1'b0, addr_q[5:0]};
    wire id_clip = (op_field == eeprom_host_pkg::OP_ID) && (id_room < cnt_lim);
    wire [6:0] eff_len = id_clip ? id_room : cnt_lim;

    // ------------------------------------------------------------
    // Frame helpers
    // ------------------------------------------------------------
    wire ack_low = !lnk.rbit;
    wire more = (got_q < len_q);
    wire lock_like = (op_q == eeprom_host_pkg::OP_LOCK) || (op_q == eeprom_host_pkg::OP_QUERY);
    wire last_tx = (idx_q == (lock_like ? 2'h3 : 2'h2));
    wire [1:0] idx_next = idx_q + 2'h1;
    wire [7:0] first_byte = tx_byte(op_q, idx_q, rd_phase_q, hw_q, addr_q);
    wire [7:0] next_byte = tx_byte(op_q, idx_next, 1'b0, hw_q, addr_q);
    wire [7:0] rx_full = {sh_q[6:0], lnk.rbit};

    assign lnk.go = go_q;
    assign lnk.cmd = (state_q == S_START) ? eeprom_host_pkg::LC_START :
                     (state_q == S_STOP) ? eeprom_host_pkg::LC_STOP :
                     (state_q == S_TX || state_q == S_RXACK) ? eeprom_host_pkg::LC_WRITE :
                     eeprom_host_pkg::LC_READ;
    // Acknowledge while more bytes are wanted, release on the last one
    assign lnk.wbit = (state_q == S_TX) ? sh_q[7] : !more;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_q <= eeprom_host_pkg::CFG_RST;
            addr_q <= eeprom_host_pkg::ADDR_RST;
            count_q <= eeprom_host_pkg::COUNT_RST;
        end else if (cfg_wr) begin
            // Settings stay frozen during a frame
            if (hit_cfg) hw_q <= pwdata[2:0];
            if (hit_addr) addr_q <= pwdata[15:0];
            if (hit_count) count_q <= pwdata[6:0];
        end
    end

    // Sticky completion flag; a new completion beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (state_q == S_STOP && wait_q && lnk.done) begin
            done_q <= 1'b1;
        end else if (done_clr || launch) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk) begin
        if (state_q == S_RX && wait_q && lnk.done && bitn_q == 3'h7) begin
            buf_mem[got_q[5:0]] <= rx_full;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            op_q <= eeprom_host_pkg::OP_CUR;
            nack_q <= 1'b0;
            locked_q <= 1'b0;
            idx_q <= 2'h0;
            bitn_q <= 3'h0;
            sh_q <= 8'h00;
            rd_phase_q <= 1'b0;
            tail_q <= 1'b0;
            len_q <= 7'h01;
            got_q <= 7'h00;
            wait_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (idle) begin
                if (launch) begin
                    op_q <= eeprom_host_pkg::op_e'(op_field);
                    rd_phase_q <= (op_field == eeprom_host_pkg::OP_CUR);
                    idx_q <= 2'h0;
                    tail_q <= 1'b0;
                    nack_q <= 1'b0;
                    got_q <= 7'h00;
                    len_q <= eff_len;
                    state_q <= S_START;
                end
            end else if (!wait_q) begin
                go_q <= 1'b1;
                wait_q <= 1'b1;
            end else if (lnk.done) begin
                wait_q <= 1'b0;
                bitn_q <= 3'h0;
                unique case (state_q)
                    S_START: begin
                        sh_q <= first_byte;
                        state_q <= tail_q ? S_STOP : S_TX;
                    end
                    S_TX: begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        bitn_q <= bitn_q + 3'h1;
                        if (bitn_q == 3'h7) state_q <= S_TXACK;
                    end
                    S_TXACK: begin
                        if (!ack_low && op_q == eeprom_host_pkg::OP_QUERY && last_tx) begin
                            locked_q <= 1'b1;
                            tail_q <= 1'b1;
                            state_q <= S_START;
                        end else if (!ack_low) begin
                            // Missing acknowledge also covers a device busy programming
                            nack_q <= 1'b1;
                            state_q <= S_STOP;
                        end else if (rd_phase_q) begin
                            state_q <= S_RX;
                        end else if (last_tx && lock_like) begin
                            locked_q <= (op_q == eeprom_host_pkg::OP_LOCK);
                            tail_q <= (op_q == eeprom_host_pkg::OP_QUERY);
                            state_q <= (op_q == eeprom_host_pkg::OP_QUERY) ? S_START : S_STOP;
                        end else if (last_tx) begin
                            rd_phase_q <= 1'b1;
                            state_q <= S_START;
                        end else begin
                            idx_q <= idx_next;
                            sh_q <= next_byte;
                            state_q <= S_TX;
                        end
                    end
                    S_RX: begin
                        sh_q <= rx_full;
                        bitn_q <= bitn_q + 3'h1;
                        if (bitn_q == 3'h7) begin
                            got_q <= got_q + 7'h01;
                            state_q <= S_RXACK;
                        end
                    end
                    S_RXACK: begin
                        // Device advances and wraps its own counter
                        state_q <= more ? S_RX : S_STOP;
                    end
                    S_STOP: begin
                        state_q <= S_IDLE;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : eeprom_host
`default_nettype wire

// ==== tb/eeprom_host_sva.sv ====
// Purpose: port-level checks of the two-wire EEPROM host
// Assumes: one clock domain, pclk
// Notes: frame content is judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
    property p_rdy_acc; pready |-> psel && penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
    property p_setup_ans; psel && !penable |=> pready; endproperty
    a_setup_ans: assert property (p_setup_ans) else $error("no answer after setup");
    property p_err_rdy; pslverr |-> pready && prdata == 32'h00000000; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("bad error response");
    property p_rd_idle; !pready |-> prdata == 32'h00000000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");
    property p_od_zero; sda_o == 1'b0; endproperty
    a_od_zero: assert property (p_od_zero) else $error("data output not low");
    property p_rst_idle; $rose(presetn) |-> scl && !sda_oe; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
    property p_scl_hi; $rose(scl) |-> scl [*8]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
    property p_scl_lo; $fell(scl) |-> !scl [*8]; endproperty
    a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
endmodule : eeprom_host_sva
bind eeprom_host eeprom_host_sva u_eeprom_host_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ==== tb/eeprom_dev_model.sv ====
// Purpose: behavioural two-wire EEPROM with ID page and lock
// Assumes: pull-up on data, host makes the clock
// Notes: contents are a fixed function of address; no write cycle delay
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [2:0] strap,
    output logic pull_low
);
    logic [7:0] sr;
    logic [7:0] ahi;
    logic [7:0] dout;
    logic [14:0] cnt = 15'h0000;
    logic [5:0] ioff = 6'h00;
    logic idp;
    logic rdm;
    logic locked = 1'b0;
    logic pend = 1'b0;
    logic drv = 1'b0;
    int ph = 0;
    int n = 0;
    assign pull_low = drv;
    always @(negedge sda) if (scl) begin
        ph = 1;
        n = 0;
        pend = 0;
        drv = 0;
    end
    always @(posedge sda) if (scl) begin
        if (pend) locked = 1;
        pend = 0;
        ph = 0;
        drv = 0;
    end
    always @(posedge scl) if (ph != 0) begin
        if (n < 8 && ph != 5) sr = {sr[6:0], sda};
        if (n == 8 && ph == 5 && sda) ph = 0;
        n = n + 1;
    end
    // Drive only after scl falls, so no false start or stop
    always @(negedge scl) if (ph != 0) begin
        if (n == 8 && ph != 5) begin
            drv = 1;
            case (ph)
                1: if (sr[7:5] != 3'b101 || sr[3:1] != strap) begin
                    drv = 0;
                    ph = 0;
                end else begin
                    idp = sr[4];
                    rdm = sr[0];
                end
                2: ahi = sr;
                3: begin
                    cnt = {ahi[6:0], sr};
                    ioff = sr[5:0];
                end
                default: if (idp && ahi[2] && sr[1]) pend = 1;
                else if (idp) drv = !locked;
            endcase
        end else if (n == 8) drv = 0;
        else if (n == 9) begin
            n = 0;
            drv = 0;
            if (ph == 1) ph = rdm ? 5 : 2;
            else if (ph < 4) ph = ph + 1;
            if (ph == 5) begin
                dout = idp ? ({2'b10, ioff} ^ 8'h33) : (cnt[7:0] ^ {1'b0, cnt[14:8]} ^ 8'h5A);
                if (idp) ioff = ioff + 1;
                else cnt = cnt + 1;
            end
        end
        if (ph == 5 && n < 8) drv = !dout[7 - n];
    end
endmodule : eeprom_dev_model
`default_nettype wire

// ==== tb/test_eeprom_host.sv ====
// Purpose: self-checking bench for the two-wire EEPROM host
// Assumes: device model on the far side, pull-up on the data line
// Notes: fixed seed, so every run is the same
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_host;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [2:0] strap = 3'h0;
    logic [31:0] prdata;
    logic [31:0] r;
    logic pready;
    logic pslverr;
    logic err_q;
    logic scl;
    logic sda_o;
    logic sda_oe;
    logic dev_low;
    logic [14:0] nxt = 15'h0000;
    int error_cnt = 0;
    int samples_checked = 0;
    wire sda = !((sda_oe && !sda_o) || dev_low);
    initial forever #12.5 pclk = ~pclk;
    eeprom_host u_eeprom_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    eeprom_dev_model u_eeprom_dev_model (.scl(scl), .sda(sda), .strap(strap), .pull_low(dev_low));
    function automatic logic [7:0] arr_v(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5A;
    endfunction : arr_v
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(r, e);
        chk({31'h0, err_q}, {31'h0, ee});
    endtask : rchk
    task automatic do_op(input logic [2:0] op, input logic [15:0] a, input logic [6:0] n,
        input logic [31:0] st_exp, input logic [31:0] mask);
        logic [14:0] s;
        logic [7:0] e;
        int k;
        int m;
        apb(1'b1, 12'h008, {16'h0000, a});
        apb(1'b1, 12'h00C, {25'h0, n});
        apb(1'b1, 12'h000, {25'h0, op, 4'h1});
        k = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0);
            k++;
        end while (r[1] !== 1'b1 && k < 5000);
        chk(r & mask, st_exp);
        m = r[14:8];
        s = (op == 3'h1) ? a[14:0] : nxt;
        for (k = 0; k < m; k++) begin
            apb(1'b0, 12'h100 + 12'(4 * k), 32'h0);
            e = (op == 3'h2) ? ({2'b10, 6'(a[5:0] + k)} ^ 8'h33) : arr_v(s + 15'(k));
            chk({24'h0, r[7:0]}, {24'h0, e});
        end
        if (op < 3'h2) nxt = s + 15'(m);
    endtask : do_op
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Tests need about 55k cycles; 100k leaves margin
    initial begin
        #2500000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(12757));
        strap = 3'($urandom);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(12'h000, 32'h0, 1'b0);
        rchk(12'h004, 32'h0, 1'b0);
        rchk(12'h008, 32'h0, 1'b0);
        rchk(12'h00C, 32'h1, 1'b0);
        rchk(12'h010, 32'h0, 1'b0);
        rchk(12'h020, 32'h0, 1'b1);
        $display("test regs done");
        apb(1'b1, 12'h004, {29'h0, strap});
        do_op(3'h1, 16'h7FFE, 7'h04, 32'h0402, 32'h7F06);
        do_op(3'h0, 16'h0000, 7'h01, 32'h0102, 32'h7F06);
        do_op(3'h1, 16'h7FFF, 7'h01, 32'h0102, 32'h7F06);
        do_op(3'h0, 16'h0000, 7'h01, 32'h0102, 32'h7F06);
        $display("test array done");
        for (int i = 0; i < 2; i++) begin
            automatic logic [6:0] n = 7'(1 + $urandom % 3);
            do_op(3'h1, 16'($urandom), n, {17'h0, n, 8'h02}, 32'h7F06);
        end
        do_op(3'h0, 16'h0000, 7'h02, 32'h0202, 32'h7F06);
        $display("test random done");
        do_op(3'h2, 16'hFF3C, 7'h0A, 32'h0402, 32'h7F06);
        $display("test id read done");
        do_op(3'h4, 16'h0000, 7'h01, 32'h0002, 32'h000E);
        do_op(3'h3, 16'h0000, 7'h01, 32'h000A, 32'h000E);
        // Host reset clears its own flag, so the next answer is the device's
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 12'h004, {29'h0, strap});
        do_op(3'h4, 16'h0000, 7'h01, 32'h000A, 32'h000E);
        $display("test lock done");
        apb(1'b1, 12'h004, {29'h0, strap ^ 3'h1});
        do_op(3'h0, 16'h0000, 7'h01, 32'h0006, 32'h0006);
        // Op code above the last one must not launch a frame
        apb(1'b1, 12'h000, 32'h00000051);
        rchk(12'h010, 32'h0000000E, 1'b0);
        rchk(12'h000, 32'h00000000, 1'b0);
        $display("test strap done");
        tally_and_finish();
    end
endmodule : test_eeprom_host
`default_nettype wire
